/* File: cdhp_cfg.svh */
// Constants for the multi-mode CD-ROM host port
// Assumes inclusion by the host port package and modules only
`ifndef CDHP_CFG_SVH
`define CDHP_CFG_SVH

// ----------------------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------------------
`define CDHP_MODE_PKT    2'h0
`define CDHP_MODE_STROBE 2'h1
`define CDHP_MODE_LATCH  2'h2

// ----------------------------------------------------------------------------
// Task-file register addresses {cs2, cs1_n, a2, a1, a0}
// ----------------------------------------------------------------------------
`define CDHP_TF_DATA     5'h10
`define CDHP_TF_STATCMD  5'h17
`define CDHP_TF_ALTSTAT  5'h0E

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CDHP_CLK_MHZ     125
`define CDHP_IORDY_NS    40
`define CDHP_IORDY_CYC   ((`CDHP_IORDY_NS * `CDHP_CLK_MHZ + 999) / 1000)

`endif

/* File: cdhp_pkg.sv */
// Types for the multi-mode CD-ROM host port
// Assumes cdhp_cfg.svh sits in the same folder
`include "cdhp_cfg.svh"
package cdhp_pkg;
  typedef enum logic [1:0]
  {
    CDHP_ST_IDLE  = 2'b00,
    CDHP_ST_WAIT  = 2'b01,
    CDHP_ST_HOLD  = 2'b10
  } cdhp_state_t;
endpackage

/* File: cdhp_sync.sv */
// Two flip-flop synchroniser bank for host pins
// Assumes one clock domain, asynchronous active-high reset
`timescale 1ns/1ps
module cdhp_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= RST;
      q_o  <= RST;
    end
    else
    begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule

/* File: cdhp_host_port.sv */
// Multi-mode CD-ROM host port: packet, strobe-status and latched-byte modes
// Assumes host pins are asynchronous; internal side is on clk_i
// Functional notes
// - Three software-selected modes change pin functions
// - Shared enable pin: port enable or chip select
// - Packet mode: ready pulled low to stretch
// - Strobe mode: wait or DMA request by select
// - Latch mode: first-byte latch pulse, pseudo-16 only
// - Packet/latch mode: sub-CPU reset on host command
// - Strobe mode: status-available output low
// - DMA request per word or at start
// - Strobe mode: data-available output low
// - Packet mode: host interrupt set/clear rules
// - Strobe mode: end-of-process on last byte
// - Latch mode: first-byte-cycle high during first byte
// - Compatibility modes use low data byte only
// - Address zero: register bit or command/data
// - Address two: register bit or door switch
// - Second select: chip select or PIO/DMA choice
// - 16-bit indicator on data port, not DMA
// - Active-low sub-CPU interrupt when pending
// - Reset clears all host port state
`timescale 1ns/1ps
`include "cdhp_cfg.svh"
module cdhp_host_port
  import cdhp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        pseudo16_i,
  input  wire logic        multiword_i,
  input  wire logic        host_port_enable_n_i,
  input  wire logic        cs2_sel_i,
  input  wire logic        host_write_strobe_n_i,
  input  wire logic        host_read_strobe_n_i,
  input  wire logic        dmack_n_i,
  input  wire logic        addr0_i,
  input  wire logic        addr1_i,
  input  wire logic        addr2_i,
  input  wire logic [15:0] host_data_bus_i,
  output logic      [15:0] host_data_bus_o,
  output logic      [15:0] host_data_bus_oe_o,
  input  wire logic        dev_ready_i,
  input  wire logic        dev_last_i,
  input  wire logic        status_ready_i,
  input  wire logic        host_irq_trigger_reg_wr_i,
  input  wire logic        subcpu_irq_pending_i,
  input  wire logic [15:0] rd_data_i,
  output logic             pin46_o,
  output logic             pin46_oe_o,
  output logic             pin47_o,
  output logic             pin48_o,
  output logic             pin48_oe_o,
  output logic             pin49_o,
  output logic             pin49_oe_o,
  output logic             iocs16_o,
  output logic             iocs16_oe_o,
  output logic             subcpu_int_n_o,
  output logic             door_status_reg_o,
  output logic             wr_stb_o,
  output logic             rd_stb_o,
  output logic [15:0]      wr_data_o,
  output logic [4:0]       reg_addr_o,
  output logic             is_dma_o,
  output logic             is_cmd_o
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [7:0] pins_s;
  cdhp_sync #(.W(8), .RST(8'hF8)) u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({host_write_strobe_n_i, host_read_strobe_n_i, dmack_n_i,
             host_port_enable_n_i, cs2_sel_i, addr2_i, addr1_i, addr0_i}),
    .q_o   (pins_s)
  );
  logic wr_n, rd_n, ack_n, cs1_n, cs2, a2, a1, a0;
  assign {wr_n, rd_n, ack_n, cs1_n, cs2, a2, a1, a0} = pins_s;

  logic pkt, stb, lat;
  assign pkt = (mode_i == `CDHP_MODE_PKT);
  assign stb = (mode_i == `CDHP_MODE_STROBE);
  assign lat = (mode_i == `CDHP_MODE_LATCH);

  // --------------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------------
  logic [4:0] tf_addr;
  logic       sel, dma_acc, data_port;
  assign tf_addr   = {cs2, cs1_n, a2, a1, a0};
  assign dma_acc   = pkt ? (!ack_n) : stb ? (!cs2 && !cs1_n) : (!cs2 && !ack_n);
  assign sel       = pkt ? (cs1_n ^ cs2) : !cs1_n;
  assign data_port = pkt && (tf_addr == `CDHP_TF_DATA);

  // --------------------------------------------------------------------------
  // Strobe edge and access state
  // --------------------------------------------------------------------------
  cdhp_state_t state, next_state;
  logic        wr_d, rd_d, next_wr_d, next_rd_d;
  logic [7:0]  cnt, next_cnt;
  logic        irq, next_irq;
  logic        srst, next_srst;
  logic        fbc, next_fbc;
  logic        fbl, next_fbl;
  logic        eop, next_eop;
  logic        drq, next_drq;
  logic        wstb, rstb, next_wstb, next_rstb;
  logic [15:0] wdat, next_wdat;
  logic        go_wr, go_rd, acc;

  assign go_wr = wr_d && !wr_n;
  assign go_rd = rd_d && !rd_n;
  assign acc   = (sel || dma_acc) && (go_wr || go_rd);

  always_comb
  begin
    next_wr_d  = wr_n;
    next_rd_d  = rd_n;
    next_state = state;
    next_cnt   = cnt;
    next_wstb  = 1'b0;
    next_rstb  = 1'b0;
    next_wdat  = wdat;
    next_irq   = irq;
    next_srst  = 1'b0;
    next_fbc   = fbc;
    next_fbl   = 1'b0;
    next_eop   = eop;
    next_drq   = drq;
    case (state)
      CDHP_ST_IDLE:
      begin
        if (acc)
        begin
          next_wstb = go_wr;
          next_rstb = go_rd;
          next_wdat = (pkt && (data_port || dma_acc)) ? host_data_bus_i
                      : {8'h00, host_data_bus_i[7:0]};
          next_cnt  = 8'(`CDHP_IORDY_CYC);
          next_state = dev_ready_i ? CDHP_ST_HOLD : CDHP_ST_WAIT;
        end
      end
      CDHP_ST_WAIT:
      begin
        if (dev_ready_i && cnt <= 8'h01)
          next_state = CDHP_ST_HOLD;
        else if (cnt != 8'h00)
          next_cnt = cnt - 8'h01;
      end
      CDHP_ST_HOLD:
      begin
        if (wr_n && rd_n)
          next_state = CDHP_ST_IDLE;
      end
      default:
        next_state = CDHP_ST_IDLE;
    endcase
    // Host interrupt: set wins over clear
    if (pkt && acc && ((go_rd && tf_addr == `CDHP_TF_STATCMD) ||
                       (go_wr && tf_addr == `CDHP_TF_STATCMD)))
      next_irq = 1'b0;
    if (pkt && host_irq_trigger_reg_wr_i)
      next_irq = 1'b1;
    if (!pkt)
      next_irq = 1'b0;
    // Sub-CPU reset from host command (device control write)
    if ((pkt || lat) && acc && go_wr && !dma_acc &&
        (pkt ? (tf_addr == `CDHP_TF_ALTSTAT && host_data_bus_i[2]) : (a0 && host_data_bus_i[7:0] == 8'h00)))
      next_srst = 1'b1;
    // DMA request
    if (!stb && dev_ready_i && !dma_acc && (pkt || !cs2))
      next_drq = 1'b1;
    if (dma_acc && acc && (lat || !multiword_i || dev_last_i))
      next_drq = 1'b0;
    if (stb)
      next_drq = !cs2 && dev_ready_i;
    // Latched-byte first-byte cycle
    if (lat && pseudo16_i && dma_acc && go_rd && !fbc)
      next_fbc = 1'b1;
    else if (lat && fbc && dma_acc && go_rd)
    begin
      next_fbc = 1'b0;
      next_fbl = 1'b1;
    end
    if (!(lat && pseudo16_i))
      next_fbc = 1'b0;
    // End of process
    if (stb && acc && dev_last_i)
      next_eop = 1'b1;
    else if (!stb || (state == CDHP_ST_IDLE && !acc && wr_n && rd_n))
      next_eop = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= CDHP_ST_IDLE;
      wr_d  <= 1'b1;
      rd_d  <= 1'b1;
      cnt   <= 8'h00;
      wstb  <= 1'b0;
      rstb  <= 1'b0;
      wdat  <= 16'h0000;
      irq   <= 1'b0;
      srst  <= 1'b0;
      fbc   <= 1'b0;
      fbl   <= 1'b0;
      eop   <= 1'b0;
      drq   <= 1'b0;
    end
    else
    begin
      state <= next_state;
      wr_d  <= next_wr_d;
      rd_d  <= next_rd_d;
      cnt   <= next_cnt;
      wstb  <= next_wstb;
      rstb  <= next_rstb;
      wdat  <= next_wdat;
      irq   <= next_irq;
      srst  <= next_srst;
      fbc   <= next_fbc;
      fbl   <= next_fbl;
      eop   <= next_eop;
      drq   <= next_drq;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  logic        n46, n46oe, n47, n48, n48oe, n49, n49oe, n16oe, nsint, ndoor;
  logic [15:0] nhd, nhdoe;
  logic [4:0]  nra;
  logic        ndma, ncmd;

  always_comb
  begin
    n46   = 1'b1;
    n46oe = 1'b0;
    n47   = 1'b1;
    n48   = 1'b0;
    n48oe = 1'b0;
    n49   = 1'b0;
    n49oe = 1'b0;
    case (mode_i)
      `CDHP_MODE_PKT:
      begin
        n46   = 1'b0;
        n46oe = (next_state == CDHP_ST_WAIT);
        n47   = !srst;
        n48   = next_drq;
        n48oe = 1'b1;
        n49   = next_irq;
        n49oe = 1'b1;
      end
      `CDHP_MODE_STROBE:
      begin
        n46   = cs2 ? (next_state != CDHP_ST_WAIT) : !next_drq;
        n46oe = 1'b1;
        n47   = !status_ready_i;
        n48   = !(dev_ready_i && !cs2);
        n48oe = 1'b1;
        n49   = !next_eop;
        n49oe = 1'b1;
      end
      `CDHP_MODE_LATCH:
      begin
        n46   = pseudo16_i && next_fbl;
        n46oe = 1'b1;
        n47   = !srst;
        n48   = next_drq;
        n48oe = 1'b1;
        n49   = next_fbc;
        n49oe = 1'b1;
      end
      default:
      begin
        n46oe = 1'b0;
      end
    endcase
    n16oe = pkt && data_port && !dma_acc && !cs1_n;
    nhdoe = 16'h0000;
    nhd   = 16'h0000;
    if (!rd_n && (sel || dma_acc))
    begin
      nhdoe = (pkt && (data_port || dma_acc)) ? 16'hFFFF : 16'h00FF;
      nhd   = rd_data_i & nhdoe;
    end
    nsint = !subcpu_irq_pending_i;
    ndoor = lat ? a2 : door_status_reg_o;
    nra   = pkt ? tf_addr : {3'h0, cs2, a0};
    ndma  = dma_acc;
    ncmd  = !pkt && a0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin46_o            <= 1'b1;
      pin46_oe_o         <= 1'b0;
      pin47_o            <= 1'b1;
      pin48_o            <= 1'b0;
      pin48_oe_o         <= 1'b0;
      pin49_o            <= 1'b0;
      pin49_oe_o         <= 1'b0;
      iocs16_oe_o        <= 1'b0;
      subcpu_int_n_o     <= 1'b1;
      door_status_reg_o  <= 1'b0;
      host_data_bus_o    <= 16'h0000;
      host_data_bus_oe_o <= 16'h0000;
      reg_addr_o         <= 5'h00;
      is_dma_o           <= 1'b0;
      is_cmd_o           <= 1'b0;
    end
    else
    begin
      pin46_o            <= n46;
      pin46_oe_o         <= n46oe;
      pin47_o            <= n47;
      pin48_o            <= n48;
      pin48_oe_o         <= n48oe;
      pin49_o            <= n49;
      pin49_oe_o         <= n49oe;
      iocs16_oe_o        <= n16oe;
      subcpu_int_n_o     <= nsint;
      door_status_reg_o  <= ndoor;
      host_data_bus_o    <= nhd;
      host_data_bus_oe_o <= nhdoe;
      reg_addr_o         <= nra;
      is_dma_o           <= ndma;
      is_cmd_o           <= ncmd;
    end
  end

  // Open-collector pin only pulls low
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      iocs16_o <= 1'b0;
    else
      iocs16_o <= 1'b0;
  end

  assign wr_stb_o  = wstb;
  assign rd_stb_o  = rstb;
  assign wr_data_o = wdat;
endmodule

/* File: cdhp_host_port_assertions.sv */
// Checker for the host port: pin timing relations
// Assumes binding to every cdhp_host_port instance
`timescale 1ns/1ps
`include "cdhp_cfg.svh"
module cdhp_host_port_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [1:0]  mode_i,
  input wire logic        pseudo16_i,
  input wire logic        host_port_enable_n_i,
  input wire logic        host_write_strobe_n_i,
  input wire logic        addr2_i,
  input wire logic        host_irq_trigger_reg_wr_i,
  input wire logic        subcpu_irq_pending_i,
  input wire logic [15:0] host_data_bus_oe_o,
  input wire logic        pin46_o,
  input wire logic        pin46_oe_o,
  input wire logic        pin47_o,
  input wire logic        pin49_o,
  input wire logic        iocs16_o,
  input wire logic        iocs16_oe_o,
  input wire logic        subcpu_int_n_o,
  input wire logic        door_status_reg_o,
  input wire logic        wr_stb_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_int_follows_pend: assert property (!$past(rst_i) && $stable(subcpu_irq_pending_i) |->
                                       subcpu_int_n_o == !subcpu_irq_pending_i)
    else $error("sub-CPU interrupt does not follow pending level");
  a_upper_byte_off: assert property (mode_i != `CDHP_MODE_PKT |-> host_data_bus_oe_o[15:8] == 8'h00)
    else $error("upper data byte driven in compatibility mode");
  a_io16_pkt_only: assert property (iocs16_oe_o |-> !iocs16_o && mode_i == `CDHP_MODE_PKT)
    else $error("16-bit indicator wrong level or mode");
  a_ready_stretch: assert property ($rose(pin46_oe_o) && mode_i == `CDHP_MODE_PKT |-> (pin46_oe_o && !pin46_o)[*5])
    else $error("ready stretch shorter than five cycles");
  a_irq_on_trigger: assert property (host_irq_trigger_reg_wr_i && mode_i == `CDHP_MODE_PKT |-> ##[1:2] pin49_o)
    else $error("host interrupt not raised by trigger");
  a_write_taken: assert property ($fell(host_write_strobe_n_i) && !host_port_enable_n_i |-> ##[3:6] wr_stb_o)
    else $error("selected write strobe not taken");
  a_subcpu_reset_n_pulse: assert property ($fell(pin47_o) && mode_i != `CDHP_MODE_STROBE |=> pin47_o)
    else $error("sub-CPU reset pulse longer than one cycle");
  a_door_level: assert property ((mode_i == `CDHP_MODE_LATCH && $stable(addr2_i))[*4] |-> door_status_reg_o == addr2_i)
    else $error("door status does not follow switch");
  a_fbl_pseudo_only: assert property (mode_i == `CDHP_MODE_LATCH && !$past(rst_i) && !$past(pseudo16_i) |->
                                      !pin46_o)
    else $error("first-byte latch high without pseudo-16 mode");

  c_stretch: cover property ($rose(pin46_oe_o) && mode_i == `CDHP_MODE_PKT);
  c_irq: cover property (host_irq_trigger_reg_wr_i ##2 pin49_o);
  c_subcpu_reset_n: cover property ($fell(pin47_o) && mode_i != `CDHP_MODE_STROBE);
endmodule

bind cdhp_host_port cdhp_host_port_assertions chk (.clk_i, .rst_i, .mode_i, .pseudo16_i, .host_port_enable_n_i,
  .host_write_strobe_n_i, .addr2_i, .host_irq_trigger_reg_wr_i, .subcpu_irq_pending_i, .host_data_bus_oe_o,
  .pin46_o, .pin46_oe_o, .pin47_o, .pin49_o, .iocs16_o, .iocs16_oe_o, .subcpu_int_n_o, .door_status_reg_o,
  .wr_stb_o);

/* File: cdhp_host_model.sv */
// Host adapter model: selects, strobes, address, data, DMA ack
// Assumes bench calls cyc; pins change at falling clock edge
`timescale 1ns/1ps
module cdhp_host_model (
  input  wire logic   clk_i,
  input  wire logic   iordy_oe_i,
  input  wire logic   dmarq_i,
  output logic        cs1_n_o,
  output logic        cs2_o,
  output logic        wr_n_o,
  output logic        rd_n_o,
  output logic        dmack_n_o,
  output logic [2:0]  adr_o,
  output logic [15:0] dat_o
);
  initial
  begin
    {cs2_o, cs1_n_o, wr_n_o, rd_n_o, dmack_n_o} = 5'h1F;
    adr_o = 3'h0;
    dat_o = 16'h0000;
  end

  // One host cycle, held while the device stretches it
  task automatic cyc(input logic [4:0] a, input logic wr, input logic [15:0] d, input logic ack);
    int k;
    @(negedge clk_i);
    {cs2_o, cs1_n_o, adr_o} = a;
    dat_o = d;
    for (k = 0; ack && !dmarq_i && k < 99; k++) @(negedge clk_i);
    dmack_n_o = !ack;
    @(negedge clk_i);
    if (wr) wr_n_o = 1'b0; else rd_n_o = 1'b0;
    for (k = 0; k < 6 || (iordy_oe_i && k < 200); k++) @(negedge clk_i);
    {wr_n_o, rd_n_o, dmack_n_o, cs1_n_o} = 4'hF;
    dat_o = ~d;
    repeat (3) @(negedge clk_i);
  endtask
endmodule

/* File: cdhp_host_port_bench.sv */
// Self-checking bench for the host port in all three modes
// Assumes package, design, checker and host model compiled first
`timescale 1ns/1ps
`include "cdhp_cfg.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", nm, e, a); end end
module cdhp_host_port_bench
  import cdhp_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, pseudo16_i = 1'b0, multiword_i = 1'b0, host_irq_trigger_reg_wr_i = 1'b0;
  logic dev_ready_i = 1'b1, dev_last_i = 1'b0, status_ready_i = 1'b0, subcpu_irq_pending_i = 1'b0, door = 1'b0;
  logic [1:0] mode_i = `CDHP_MODE_PKT;
  logic [15:0] rd_data_i = 16'h0000, host_data_bus_o, host_data_bus_oe_o, wr_data_o, cap_d, d;
  logic [15:0] cap_oe, cap_rd, cap_rv;
  logic live = 1'b0;
  wire logic host_port_enable_n_i, cs2_sel_i, host_write_strobe_n_i, host_read_strobe_n_i, dmack_n_i;
  wire logic addr0_i, addr1_i, adr2, addr2_i;
  wire logic [15:0] host_data_bus_i;
  logic pin46_o, pin46_oe_o, pin47_o, pin48_o, pin48_oe_o, pin49_o, pin49_oe_o, iocs16_o, iocs16_oe_o;
  logic subcpu_int_n_o, door_status_reg_o, wr_stb_o, rd_stb_o, is_dma_o, is_cmd_o, cap_cmd, cap_dma;
  logic [4:0] reg_addr_o, cap_a, a;
  int err_total = 0, n_checks = 0, seed = 76, cycles = 0, n_wr = 0, n_rst = 0, n_io = 0, i, m;
  int n_rd = 0, n_fbl = 0;

  assign addr2_i = (mode_i == `CDHP_MODE_LATCH) ? door : adr2;
  cdhp_host_port DUT (.clk_i, .rst_i, .mode_i, .pseudo16_i, .multiword_i, .host_port_enable_n_i, .cs2_sel_i,
    .host_write_strobe_n_i, .host_read_strobe_n_i, .dmack_n_i, .addr0_i, .addr1_i, .addr2_i, .host_data_bus_i,
    .host_data_bus_o, .host_data_bus_oe_o, .dev_ready_i, .dev_last_i, .status_ready_i, .host_irq_trigger_reg_wr_i,
    .subcpu_irq_pending_i, .rd_data_i, .pin46_o, .pin46_oe_o, .pin47_o, .pin48_o, .pin48_oe_o, .pin49_o,
    .pin49_oe_o, .iocs16_o, .iocs16_oe_o, .subcpu_int_n_o, .door_status_reg_o, .wr_stb_o, .rd_stb_o, .wr_data_o,
    .reg_addr_o, .is_dma_o, .is_cmd_o);
  cdhp_host_model hm (.clk_i, .iordy_oe_i(pin46_oe_o && !pin46_o && mode_i != `CDHP_MODE_LATCH),
    .dmarq_i(pin48_o && pin48_oe_o), .cs1_n_o(host_port_enable_n_i), .cs2_o(cs2_sel_i),
    .wr_n_o(host_write_strobe_n_i), .rd_n_o(host_read_strobe_n_i), .dmack_n_o(dmack_n_i),
    .adr_o({adr2, addr1_i, addr0_i}), .dat_o(host_data_bus_i));

  always #4 clk_i = ~clk_i;

  // Random internal side, timeout and output monitor
  always @(negedge clk_i)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      err_total++;
      test_done();
    end
    if (live && mode_i == `CDHP_MODE_STROBE)
      `CHK("status_avail", !status_ready_i, pin47_o)
    if (live)
      `CHK("subcpu_int", !subcpu_irq_pending_i, subcpu_int_n_o)
    live = !rst_i;
    if (wr_stb_o === 1'b1)
    begin
      n_wr++;
      {cap_d, cap_a, cap_cmd, cap_dma} = {wr_data_o, reg_addr_o, is_cmd_o, is_dma_o};
    end
    if (rd_stb_o === 1'b1)
    begin
      n_rd++;
      {cap_oe, cap_rd, cap_rv} = {host_data_bus_oe_o, host_data_bus_o, rd_data_i};
    end
    if (pin47_o === 1'b0) n_rst++;
    if (iocs16_oe_o === 1'b1) n_io++;
    if (mode_i == `CDHP_MODE_LATCH && pin46_o === 1'b1) n_fbl++;
    {dev_ready_i, dev_last_i, status_ready_i, subcpu_irq_pending_i} = 4'($random(seed));
    rd_data_i = 16'($random(seed));
  end

  function automatic logic [1:0] exp_flags(input logic [4:0] ad);
    return {ad[0], !ad[4]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic go(input logic [1:0] md);
    rst_i = 1'b1;
    mode_i = md;
    repeat (2) @(negedge clk_i);
    `CHK("rst_pin47", 1'b1, pin47_o)
    `CHK("rst_io16", 1'b0, iocs16_oe_o)
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic wr(input logic [4:0] ad, input logic [15:0] dv);
    n_wr = 0;
    hm.cyc(ad, 1'b1, dv, mode_i == `CDHP_MODE_LATCH && !ad[4]);
    `CHK("wr_count", 1'b1, n_wr == 1)
    `CHK("wr_low", dv[7:0], cap_d[7:0])
    if (mode_i != `CDHP_MODE_PKT)
      `CHK("wr_flags", exp_flags(ad), {cap_cmd, cap_dma})
    else
      `CHK("wr_addr", ad, cap_a)
    if (ad == `CDHP_TF_DATA && mode_i == `CDHP_MODE_PKT)
      `CHK("wr_high", dv[15:8], cap_d[15:8])
  endtask

  initial
  begin
    repeat (12) @(negedge clk_i);
    for (m = 0; m < 3; m++)
    begin
      go(2'(m));
      for (i = 0; i < 8; i++)
      begin
        a = 5'($random(seed));
        d = 16'($random(seed));
        a = (m == 0) ? {2'b10, a[2:0]} : {a[4], 1'b0, a[2], 1'b0, a[0]};
        if (i == 0) a = (m == 0) ? `CDHP_TF_DATA : 5'h11;
        wr(a, d);
      end
      $display("mode %0d writes done", m);
    end
    n_wr = 0;
    hm.cyc(5'h18, 1'b1, 16'h0055, 1'b0);
    `CHK("unselected", 1'b1, n_wr == 0)
    $display("unselected write done");
    go(`CDHP_MODE_PKT);
    for (i = 0; i < 2; i++)
    begin
      host_irq_trigger_reg_wr_i = 1'b1;
      @(negedge clk_i);
      host_irq_trigger_reg_wr_i = 1'b0;
      repeat (2) @(negedge clk_i);
      `CHK("irq_set", 1'b1, pin49_o)
      hm.cyc(`CDHP_TF_STATCMD, i[0], 16'h00A1, 1'b0);
      `CHK("irq_clear", 1'b0, pin49_o)
    end
    n_io = 0;
    hm.cyc(`CDHP_TF_STATCMD, 1'b0, 16'h0000, 1'b0);
    `CHK("io16_status", 1'b1, n_io == 0)
    hm.cyc(`CDHP_TF_DATA, 1'b0, 16'h0000, 1'b0);
    `CHK("io16_data", 1'b1, n_io > 0)
    `CHK("rd_oe_pkt", 16'hFFFF, cap_oe)
    `CHK("rd_data_pkt", cap_rv, cap_rd)
    n_io = 0;
    n_wr = 0;
    hm.cyc(5'h18, 1'b1, 16'hBEEF, 1'b1);
    `CHK("dma_taken", 2'h3, {n_wr == 1, cap_dma})
    `CHK("dma_io16", 1'b1, n_io == 0)
    `CHK("dma_data", 16'hBEEF, cap_d)
    n_rst = 0;
    wr(`CDHP_TF_ALTSTAT, 16'h0004);
    `CHK("subcpu_reset_n_pkt", 1'b1, n_rst == 1)
    $display("packet mode tests done");
    go(`CDHP_MODE_LATCH);
    n_rst = 0;
    wr(5'h11, 16'h0000);
    `CHK("subcpu_reset_n_latch", 1'b1, n_rst == 1)
    n_rd = 0;
    hm.cyc(5'h10, 1'b0, 16'h0000, 1'b0);
    `CHK("rd_count", 1'b1, n_rd == 1)
    `CHK("rd_oe_low", 16'h00FF, cap_oe)
    `CHK("rd_low", {8'h00, cap_rv[7:0]}, cap_rd)
    for (i = 0; i < 2; i++)
    begin
      door = ~door;
      repeat (5) @(negedge clk_i);
      `CHK("door", door, door_status_reg_o)
    end
    pseudo16_i = 1'b1;
    n_fbl = 0;
    // Two DMA halves back to back, no PIO access between them
    hm.cyc(5'h00, 1'b0, 16'h0000, 1'b1);
    `CHK("fbc_first", 1'b1, pin49_o)
    hm.cyc(5'h00, 1'b0, 16'h0000, 1'b1);
    `CHK("fbc_second", 1'b0, pin49_o)
    `CHK("fbl_pulse", 1'b1, n_fbl == 1)
    $display("latch mode tests done");
    test_done();
  end
endmodule
